/* File: por_monitor_pkg.sv */
/*
 * constants and types for the power-on reset sequencer and supply monitor
 * control block.
 * assumes a single 125 MHz clock and a classic wishbone register bus with
 * word-aligned registers; printed register offsets are word indexes.
 */
package por_monitor_pkg;

   // clock rate and release timing
   localparam int CLK_FREQ_MHZ = 125;
   localparam int POR_DELAY_NS = 100000;   // release delay, plain default
   localparam int POR_DELAY_CYCLES =
      (POR_DELAY_NS * CLK_FREQ_MHZ + 999) / 1000;
   localparam int OTHER_RST_NS = 128;      // reset pulse for other sources
   localparam int OTHER_RST_CYCLES =
      (OTHER_RST_NS * CLK_FREQ_MHZ + 999) / 1000;
   localparam int PIN_SETTLE_CYCLES = 3;   // pin read-back blanking
   localparam int CNT_W = 24;

   // register word indexes (byte address = 4 * index)
   localparam logic [7:0] SRC_INDEX = 8'h00;
   localparam logic [7:0] IRQ_STAT_INDEX = 8'h01;
   localparam logic [7:0] IRQ_MASK_INDEX = 8'h02;
   localparam logic [7:0] CTRL_INDEX = 8'hff;

   // supply_monitor_control fields
   localparam int CTRL_PRI_EN_BIT = 7;
   localparam int CTRL_STAT_BIT = 6;
   localparam int CTRL_LVL_SEL_BIT = 5;
   localparam int CTRL_LVL_EN_BIT = 4;
   localparam logic CTRL_PRI_EN_RST = 1'h1;
   localparam logic CTRL_LVL_SEL_RST = 1'h0;
   localparam logic CTRL_LVL_EN_RST = 1'h1;

   // reset_source_register fields
   localparam int SRC_PIN_BIT = 0;
   localparam int SRC_POR_BIT = 1;
   localparam int SRC_LVL_BIT = 2;

   // interrupt status and mask fields
   localparam int IRQ_W = 3;
   localparam int IRQ_FELL_BIT = 0;
   localparam int IRQ_ROSE_BIT = 1;
   localparam int IRQ_LVL_BIT = 2;
   localparam logic [IRQ_W-1:0] IRQ_MASK_RST = 3'h0;

   // core start address after any reset
   localparam logic [15:0] RESET_VECTOR = 16'h0000;

   // sequencer states
   typedef enum logic [1:0] {
      ST_HOLD = 2'b00,
      ST_DELAY = 2'b01,
      ST_RUN = 2'b10,
      ST_OTHER = 2'b11
   } seq_state_type;

endpackage

/* File: power_on_reset_supply_monitor.sv */
/*
 * power-on reset sequencer with supply monitor control, reset cause
 * flags, interrupt status/mask and a classic wishbone register slave.
 * assumes the supply comparators, level monitor and reset pin are
 * asynchronous to clk_i, and that rst_i is held while the clock starts.
 */
// The Wishbone slave port was decided locally.
// Function
// - while the supply is below the reset threshold the device is held in reset and the reset pin driven low.
// - after the supply passes the threshold a further release delay runs before reset is released.
// - leaving a power-on reset sets the power-on flag, bit 1 of the reset source register.
// - while the power-on flag is set the other cause flags carry no meaning for software.
// - any reset source other than power-on clears the power-on flag.
// - whatever the source, the core starts fetching at address 0x0000 when reset ends.
// - after power-on both the primary and the level supply monitors come up enabled.
// - control bit 5 selects the high threshold when one and the low one when zero.
`timescale 1ns/100ps

module power_on_reset_supply_monitor #(
   parameter int unsigned POR_DELAY_CYCLES = por_monitor_pkg::POR_DELAY_CYCLES
) (
   // clock and reset
   input wire logic clk_i,
   input wire logic rst_i,
   // wishbone slave
   input wire logic cyc_i,
   input wire logic stb_i,
   input wire logic we_i,
   input wire logic [3:0] sel_i,
   input wire logic [9:0] adr_i,
   input wire logic [31:0] dat_i,
   output logic [31:0] dat_o,
   output logic ack_o,
   // supply comparators
   input wire logic supply_above_i,
   input wire logic level_trip_i,
   // open-drain reset pin, active low
   input wire logic rst_pin_i,
   output logic rst_pin_o,
   output logic rst_pin_oe_o,
   // core side
   output logic core_reset_o,
   output logic [15:0] fetch_addr_o,
   // monitor controls
   output logic primary_mon_en_o,
   output logic threshold_high_o,
   output logic level_mon_en_o,
   // interrupt
   output logic irq_o
);

   localparam int CW = por_monitor_pkg::CNT_W;
   localparam logic [CW-1:0] POR_LAST = CW'(POR_DELAY_CYCLES - 1);
   localparam logic [CW-1:0] OTHER_LAST =
      CW'(por_monitor_pkg::OTHER_RST_CYCLES - 1);
   localparam logic [1:0] SETTLE_LAST =
      2'(por_monitor_pkg::PIN_SETTLE_CYCLES - 1);

   // word index decode, shared by read and write paths
   function automatic logic reg_hit(input logic [9:0] adr,
                                    input logic [7:0] idx);
      reg_hit = (adr[9:2] == idx);
   endfunction

   ////////////////////////////////////////////////////////////////////////
   // input synchronisers

   logic [2:0] async_in;
   logic [2:0] sync1_q;
   logic [2:0] sync2_q;
   logic supply_ok;
   logic level_trip;
   logic pin_low;

   assign async_in = {rst_pin_i, level_trip_i, supply_above_i};

   // two flops per line; only the second stage feeds logic
   genvar gi;
   generate
      for (gi = 0; gi < 3; gi++)
      begin : g_sync
         always_ff @(posedge clk_i)
         begin
            if (rst_i)
            begin
               sync1_q[gi] <= 1'h0;
               sync2_q[gi] <= 1'h0;
            end
            else
            begin
               sync1_q[gi] <= async_in[gi];
               sync2_q[gi] <= sync1_q[gi];
            end
         end
      end
   endgenerate

   assign supply_ok = sync2_q[0];
   assign level_trip = sync2_q[1];
   assign pin_low = ~sync2_q[2];

   ////////////////////////////////////////////////////////////////////////
   // reset sequencer

   por_monitor_pkg::seq_state_type state_q;
   logic [CW-1:0] cnt_q;
   logic pri_en_q;
   logic lvl_sel_q;
   logic lvl_en_q;
   logic drive_q;
   logic [1:0] settle_q;
   logic brownout;
   logic lvl_reset;
   logic pin_reset;

   // a dropping supply outranks every other cause
   assign brownout = pri_en_q & ~supply_ok;
   assign lvl_reset = lvl_en_q & level_trip;
   // our own pin drive reads back low for a while; blank it
   assign pin_reset = pin_low & ~drive_q & (settle_q == SETTLE_LAST);

   always_ff @(posedge clk_i)
   begin
      if (rst_i)
      begin
         state_q <= por_monitor_pkg::ST_HOLD;
         cnt_q <= '0;
      end
      else
      begin
         unique case (state_q)
            por_monitor_pkg::ST_HOLD:
            begin
               cnt_q <= '0;
               if (supply_ok)
                  state_q <= por_monitor_pkg::ST_DELAY;
            end
            por_monitor_pkg::ST_DELAY:
            begin
               if (!supply_ok)
               begin
                  state_q <= por_monitor_pkg::ST_HOLD;
                  cnt_q <= '0;
               end
               else if (cnt_q == POR_LAST)
                  state_q <= por_monitor_pkg::ST_RUN;
               else
                  cnt_q <= cnt_q + 1'h1;
            end
            por_monitor_pkg::ST_RUN:
            begin
               cnt_q <= '0;
               if (brownout)
                  state_q <= por_monitor_pkg::ST_HOLD;
               else if (lvl_reset || pin_reset)
                  state_q <= por_monitor_pkg::ST_OTHER;
            end
            por_monitor_pkg::ST_OTHER:
            begin
               if (brownout)
               begin
                  state_q <= por_monitor_pkg::ST_HOLD;
                  cnt_q <= '0;
               end
               else if (cnt_q == OTHER_LAST)
                  state_q <= por_monitor_pkg::ST_RUN;
               else
                  cnt_q <= cnt_q + 1'h1;
            end
         endcase
      end
   end

   // reset drive, pin blanking and start address
   always_ff @(posedge clk_i)
   begin
      if (rst_i)
      begin
         drive_q <= 1'h1;
         settle_q <= 2'h0;
         fetch_addr_o <= por_monitor_pkg::RESET_VECTOR;
      end
      else
      begin
         drive_q <= (state_q != por_monitor_pkg::ST_RUN);
         if (drive_q)
            settle_q <= 2'h0;
         else if (settle_q != SETTLE_LAST)
            settle_q <= settle_q + 2'h1;
         if (drive_q)
            fetch_addr_o <= por_monitor_pkg::RESET_VECTOR;
      end
   end

   assign rst_pin_o = 1'h0;
   assign rst_pin_oe_o = drive_q;
   assign core_reset_o = drive_q;

   ////////////////////////////////////////////////////////////////////////
   // wishbone access

   logic ack_q;
   logic access;
   logic wr_ctrl;
   logic wr_mask;
   logic rd_stat;
   logic [2:0] src_q;
   logic [por_monitor_pkg::IRQ_W-1:0] stat_q;
   logic [por_monitor_pkg::IRQ_W-1:0] mask_q;
   logic [7:0] ctrl_rd;

   // one wait cycle: ack a cycle after the request is seen
   assign access = cyc_i & stb_i & ~ack_q;
   assign wr_ctrl = access & we_i & sel_i[0] &
                    reg_hit(adr_i, por_monitor_pkg::CTRL_INDEX);
   assign wr_mask = access & we_i & sel_i[0] &
                    reg_hit(adr_i, por_monitor_pkg::IRQ_MASK_INDEX);
   assign rd_stat = access & ~we_i &
                    reg_hit(adr_i, por_monitor_pkg::IRQ_STAT_INDEX);

   // low nibble is reserved and reads zero; status bit is live
   always_comb
   begin
      ctrl_rd = 8'h00;
      ctrl_rd[por_monitor_pkg::CTRL_PRI_EN_BIT] = pri_en_q;
      ctrl_rd[por_monitor_pkg::CTRL_STAT_BIT] = supply_ok;
      ctrl_rd[por_monitor_pkg::CTRL_LVL_SEL_BIT] = lvl_sel_q;
      ctrl_rd[por_monitor_pkg::CTRL_LVL_EN_BIT] = lvl_en_q;
   end

   // unmapped words ack with zero data
   always_ff @(posedge clk_i)
   begin
      if (rst_i)
      begin
         ack_q <= 1'h0;
         dat_o <= 32'h0000_0000;
      end
      else
      begin
         ack_q <= access;
         if (access && !we_i)
         begin
            if (reg_hit(adr_i, por_monitor_pkg::CTRL_INDEX))
               dat_o <= {24'h000000, ctrl_rd};
            else if (reg_hit(adr_i, por_monitor_pkg::SRC_INDEX))
               dat_o <= {29'h0, src_q};
            else if (reg_hit(adr_i, por_monitor_pkg::IRQ_STAT_INDEX))
               dat_o <= {29'h0, stat_q};
            else if (reg_hit(adr_i, por_monitor_pkg::IRQ_MASK_INDEX))
               dat_o <= {29'h0, mask_q};
            else
               dat_o <= 32'h0000_0000;
         end
      end
   end

   assign ack_o = ack_q;

   ////////////////////////////////////////////////////////////////////////
   // supply monitor control; power loss restores the defaults

   always_ff @(posedge clk_i)
   begin
      if (rst_i || state_q == por_monitor_pkg::ST_HOLD)
      begin
         pri_en_q <= por_monitor_pkg::CTRL_PRI_EN_RST;
         lvl_sel_q <= por_monitor_pkg::CTRL_LVL_SEL_RST;
         lvl_en_q <= por_monitor_pkg::CTRL_LVL_EN_RST;
      end
      else if (wr_ctrl)
      begin
         pri_en_q <= dat_i[por_monitor_pkg::CTRL_PRI_EN_BIT];
         lvl_sel_q <= dat_i[por_monitor_pkg::CTRL_LVL_SEL_BIT];
         lvl_en_q <= dat_i[por_monitor_pkg::CTRL_LVL_EN_BIT];
      end
   end

   assign primary_mon_en_o = pri_en_q;
   assign threshold_high_o = lvl_sel_q;
   assign level_mon_en_o = lvl_en_q;

   ////////////////////////////////////////////////////////////////////////
   // reset cause flags, read only to software

   always_ff @(posedge clk_i)
   begin
      if (rst_i || state_q == por_monitor_pkg::ST_HOLD)
         src_q <= 3'h0;                  // all cause flags zero
      else if (state_q == por_monitor_pkg::ST_DELAY && cnt_q == POR_LAST
               && supply_ok)
         src_q[por_monitor_pkg::SRC_POR_BIT] <= 1'h1;
      else if (state_q == por_monitor_pkg::ST_RUN && !brownout
               && (lvl_reset || pin_reset))
      begin
         src_q[por_monitor_pkg::SRC_POR_BIT] <= 1'h0;
         src_q[por_monitor_pkg::SRC_LVL_BIT] <= lvl_reset;
         src_q[por_monitor_pkg::SRC_PIN_BIT] <= pin_reset & ~lvl_reset;
      end
   end

   ////////////////////////////////////////////////////////////////////////
   // interrupt status: read clears, a new event wins over the clear

   logic supply_d1_q;
   logic trip_d1_q;
   logic [por_monitor_pkg::IRQ_W-1:0] events;

   always_ff @(posedge clk_i)
   begin
      if (rst_i)
      begin
         supply_d1_q <= 1'h0;
         trip_d1_q <= 1'h0;
      end
      else
      begin
         supply_d1_q <= supply_ok;
         trip_d1_q <= level_trip;
      end
   end

   always_comb
   begin
      events = '0;
      events[por_monitor_pkg::IRQ_FELL_BIT] = supply_d1_q & ~supply_ok;
      events[por_monitor_pkg::IRQ_ROSE_BIT] = ~supply_d1_q & supply_ok;
      events[por_monitor_pkg::IRQ_LVL_BIT] = ~trip_d1_q & level_trip;
   end

   always_ff @(posedge clk_i)
   begin
      if (rst_i)
         stat_q <= '0;
      else if (rd_stat)
         stat_q <= events;
      else
         stat_q <= stat_q | events;
   end

   always_ff @(posedge clk_i)
   begin
      if (rst_i)
         mask_q <= por_monitor_pkg::IRQ_MASK_RST;
      else if (wr_mask)
         mask_q <= dat_i[por_monitor_pkg::IRQ_W-1:0];
   end

   assign irq_o = |(stat_q & mask_q);

   ////////////////////////////////////////////////////////////////////////
   // checks

   default clocking cb @(posedge clk_i); endclocking
   default disable iff (rst_i);

   hold_pin_low_a: assert property (
      (state_q == por_monitor_pkg::ST_HOLD) |=> rst_pin_oe_o && core_reset_o)
      else $error("reset not driven while supply low");

   delay_length_a: assert property (
      (state_q == por_monitor_pkg::ST_RUN) &&
      ($past(state_q) == por_monitor_pkg::ST_DELAY)
      |-> $past(cnt_q) == POR_LAST)
      else $error("released before release delay ran out");

   por_flag_set_a: assert property (
      (state_q == por_monitor_pkg::ST_RUN) &&
      ($past(state_q) == por_monitor_pkg::ST_DELAY)
      |-> src_q[por_monitor_pkg::SRC_POR_BIT])
      else $error("power-on flag not set on release");

   por_flag_alone_a: assert property (
      src_q[por_monitor_pkg::SRC_POR_BIT]
      |-> !src_q[por_monitor_pkg::SRC_LVL_BIT] &&
          !src_q[por_monitor_pkg::SRC_PIN_BIT])
      else $error("cause flags set beside power-on flag");

   other_clears_por_a: assert property (
      $rose(state_q == por_monitor_pkg::ST_OTHER)
      |-> !src_q[por_monitor_pkg::SRC_POR_BIT] &&
          (src_q[por_monitor_pkg::SRC_LVL_BIT] ||
           src_q[por_monitor_pkg::SRC_PIN_BIT]))
      else $error("other reset left power-on flag set");

   start_vector_a: assert property (
      $fell(core_reset_o) |-> fetch_addr_o == por_monitor_pkg::RESET_VECTOR)
      else $error("core released with wrong start address");

   monitors_on_a: assert property (
      (state_q == por_monitor_pkg::ST_HOLD) ##1
      (state_q == por_monitor_pkg::ST_DELAY)
      |-> primary_mon_en_o && level_mon_en_o)
      else $error("monitors not enabled after power-on");

   threshold_write_a: assert property (
      wr_ctrl && (state_q != por_monitor_pkg::ST_HOLD)
      |=> threshold_high_o == $past(dat_i[por_monitor_pkg::CTRL_LVL_SEL_BIT]))
      else $error("threshold select did not follow write");

   status_read_a: assert property (
      access && !we_i && reg_hit(adr_i, por_monitor_pkg::CTRL_INDEX)
      |=> ack_o && dat_o[por_monitor_pkg::CTRL_STAT_BIT] == $past(supply_ok)
          && dat_o[3:0] == 4'h0)
      else $error("control read shows wrong supply status");

   level_reset_a: assert property (
      (state_q == por_monitor_pkg::ST_RUN) && lvl_en_q && level_trip &&
      !brownout |=> (state_q == por_monitor_pkg::ST_OTHER) ##1 rst_pin_oe_o)
      else $error("level monitor trip did not reset");

   por_release_c: cover property (
      (state_q == por_monitor_pkg::ST_DELAY) ##1
      (state_q == por_monitor_pkg::ST_RUN));
   brownout_c: cover property (
      (state_q == por_monitor_pkg::ST_RUN) ##1
      (state_q == por_monitor_pkg::ST_HOLD));
   other_reset_c: cover property (
      (state_q == por_monitor_pkg::ST_OTHER) ##1
      (state_q == por_monitor_pkg::ST_RUN));
   irq_raise_c: cover property ($rose(irq_o));

endmodule // power_on_reset_supply_monitor

/* File: supply_comparator_model.sv */
/*
 * behavioural model of the far side: the supply comparators and the
 * open-drain reset pin with its pull-up and an external pull-down.
 * assumes the bench changes its commands just after a rising clock edge.
 */
`timescale 1ns/100ps

module supply_comparator_model (
   // commands from the bench
   input wire logic supply_cmd_i,
   input wire logic trip_cmd_i,
   input wire logic pin_low_cmd_i,
   // open-drain reset pin from the block
   input wire logic pin_data_i,
   input wire logic pin_oe_i,
   // comparator outputs and resolved pin
   output logic supply_above_o,
   output logic level_trip_o,
   output logic pin_level_o
);

   ////////////////////////////////////////////////////////////////////////
   // comparators report the supply that the system watches
   assign supply_above_o = supply_cmd_i;
   assign level_trip_o = trip_cmd_i;

   ////////////////////////////////////////////////////////////////////////
   // pull-up wins unless either party pulls low, so no stale level remains
   assign pin_level_o = ~((pin_oe_i & ~pin_data_i) | pin_low_cmd_i);

endmodule // supply_comparator_model

/* File: tb_power_on_reset_supply_monitor.sv */
/*
 * self-checking bench for the power-on reset sequencer: wishbone tasks,
 * supply, level-trip and pin-reset sequences with expected values.
 * assumes the far side is supply_comparator_model and a short delay.
 */
`timescale 1ns/100ps

module tb_power_on_reset_supply_monitor;
   localparam int unsigned DLY = 8; // short release delay keeps the run brief
   localparam logic [7:0] SRC = por_monitor_pkg::SRC_INDEX;
   localparam logic [7:0] IRQS = por_monitor_pkg::IRQ_STAT_INDEX;
   localparam logic [7:0] MASK = por_monitor_pkg::IRQ_MASK_INDEX;
   localparam logic [7:0] CTRL = por_monitor_pkg::CTRL_INDEX;
   logic clk_i = 1'b0;
   logic rst_i = 1'b1;
   logic cyc_i = 1'b0;
   logic stb_i = 1'b0;
   logic we_i = 1'b0;
   logic [3:0] sel_i = 4'h0;
   logic [9:0] adr_i = 10'h000;
   logic [31:0] dat_i = 32'h00000000;
   logic supply_cmd = 1'b0;
   logic trip_cmd = 1'b0;
   logic pin_low_cmd = 1'b0;
   logic supply_above_i;
   logic level_trip_i;
   logic rst_pin_i;
   logic [31:0] dat_o;
   logic ack_o;
   logic rst_pin_o;
   logic rst_pin_oe_o;
   logic core_reset_o;
   logic [15:0] fetch_addr_o;
   logic primary_mon_en_o;
   logic threshold_high_o;
   logic level_mon_en_o;
   logic irq_o;
   logic [31:0] rdata;
   int n_mismatch = 0;
   int comparisons = 0;

   always #4 clk_i = ~clk_i;

   power_on_reset_supply_monitor #(.POR_DELAY_CYCLES(DLY)) i_dut (
      .clk_i(clk_i), .rst_i(rst_i), .cyc_i(cyc_i), .stb_i(stb_i),
      .we_i(we_i), .sel_i(sel_i), .adr_i(adr_i), .dat_i(dat_i),
      .dat_o(dat_o), .ack_o(ack_o), .supply_above_i(supply_above_i),
      .level_trip_i(level_trip_i), .rst_pin_i(rst_pin_i),
      .rst_pin_o(rst_pin_o), .rst_pin_oe_o(rst_pin_oe_o),
      .core_reset_o(core_reset_o), .fetch_addr_o(fetch_addr_o),
      .primary_mon_en_o(primary_mon_en_o),
      .threshold_high_o(threshold_high_o),
      .level_mon_en_o(level_mon_en_o), .irq_o(irq_o));

   supply_comparator_model i_model (
      .supply_cmd_i(supply_cmd), .trip_cmd_i(trip_cmd),
      .pin_low_cmd_i(pin_low_cmd), .pin_data_i(rst_pin_o),
      .pin_oe_i(rst_pin_oe_o), .supply_above_o(supply_above_i),
      .level_trip_o(level_trip_i), .pin_level_o(rst_pin_i));

   ////////////////////////////////////////////////////////////////////////
   // helpers: settle after edges, compare, bus cycle, wait for core reset
   task automatic tick(input int n);
      repeat (n) @(posedge clk_i);
      #1;
   endtask

   task automatic chk(input logic [31:0] seen, input logic [31:0] exp,
                      input string what);
      comparisons++;
      if (seen !== exp)
      begin
         n_mismatch++;
         $display("wrong value at %0t: %s seen %h expected %h", $time,
                  what, seen, exp);
      end
   endtask

   // classic cycle: hold everything until ack is sampled, then release
   task automatic bus(input logic wr, input logic [7:0] idx,
                      input logic [7:0] wdat, input logic [3:0] sel);
      int n;
      n = 0;
      @(posedge clk_i);
      cyc_i <= 1'b1;
      stb_i <= 1'b1;
      we_i <= wr;
      sel_i <= sel;
      adr_i <= {idx, 2'b00};
      dat_i <= {24'h000000, wdat};
      do
      begin
         @(posedge clk_i);
         n++;
      end
      while (ack_o !== 1'b1 && n < 20);
      rdata = dat_o;
      cyc_i <= 1'b0;
      stb_i <= 1'b0;
      we_i <= 1'b0;
      if (n >= 20)
         chk(32'h0, 32'h1, "bus answer missing");
   endtask

   task automatic wr(input logic [7:0] idx, input logic [7:0] wdat);
      bus(1'b1, idx, wdat, 4'h1);
   endtask

   task automatic rd_chk(input logic [7:0] idx, input logic [7:0] exp,
                         input string what);
      bus(1'b0, idx, 8'h00, 4'hf);
      chk({24'h000000, rdata[7:0]}, {24'h000000, exp}, what);
   endtask

   // bounded wait; a level that never comes is a mismatch
   task automatic wait_core(input logic lvl, input int lim);
      int n;
      n = 0;
      while (core_reset_o !== lvl && n < lim)
      begin
         @(posedge clk_i);
         n++;
      end
      chk(core_reset_o, lvl, "core reset level");
   endtask

   task automatic close_out;
      $display("mismatches %0d comparisons %0d", n_mismatch, comparisons);
      if (n_mismatch == 0 && comparisons > 0)
         $display("TEST PASSED");
      else
         $display("TEST FAILED");
      $finish;
   endtask

   ////////////////////////////////////////////////////////////////////////
   // watchdog: the sequence needs well under a thousand cycles
   initial
   begin
      #(8 * 5000);
      n_mismatch++;
      close_out();
   end

   ////////////////////////////////////////////////////////////////////////
   // main sequence
   initial
   begin
      repeat (8) @(posedge clk_i);
      rst_i <= 1'b0;
      tick(20);
      chk(core_reset_o, 1'b1, "core held, supply low");
      chk(rst_pin_i, 1'b0, "pin low, supply low");
      rd_chk(CTRL, 8'h90, "control defaults");
      rd_chk(SRC, 8'h00, "source in hold");
      // power-up: release exactly after sync, hold and delay
      @(posedge clk_i);
      supply_cmd <= 1'b1;
      tick(DLY + 3);
      chk(core_reset_o, 1'b1, "released early");
      tick(1);
      chk(core_reset_o, 1'b0, "release late");
      chk(rst_pin_i, 1'b1, "pin released");
      chk(fetch_addr_o, 16'h0000, "start address");
      chk(primary_mon_en_o, 1'b1, "primary on");
      chk(level_mon_en_o, 1'b1, "level on");
      rd_chk(SRC, 8'h02, "power-on flag");
      // software raises the threshold at once; low nibble must not stick
      wr(CTRL, 8'hbf);
      tick(2);
      chk(threshold_high_o, 1'b1, "high threshold");
      rd_chk(CTRL, 8'hf0, "control read back");
      wr(CTRL, 8'h90);
      tick(2);
      chk(threshold_high_o, 1'b0, "low threshold");
      bus(1'b1, CTRL, 8'h20, 4'h0);
      rd_chk(CTRL, 8'hd0, "write without lane");
      rd_chk(8'h10, 8'h00, "unmapped read");
      // level trip: other reset clears the flag, interrupt raised
      bus(1'b0, IRQS, 8'h00, 4'hf);
      wr(MASK, 8'h04);
      rd_chk(MASK, 8'h04, "mask read back");
      @(posedge clk_i);
      trip_cmd <= 1'b1;
      wait_core(1'b1, 10);
      trip_cmd <= 1'b0;
      wait_core(1'b0, 40);
      tick(1);
      chk(fetch_addr_o, 16'h0000, "start after trip");
      chk(irq_o, 1'b1, "trip interrupt");
      rd_chk(SRC, 8'h04, "level cause");
      rd_chk(IRQS, 8'h04, "trip status");
      tick(2);
      chk(irq_o, 1'b0, "status cleared by read");
      // level monitor off: a trip is no reset source
      wr(CTRL, 8'ha0);
      tick(2);
      chk(level_mon_en_o, 1'b0, "level off");
      @(posedge clk_i);
      trip_cmd <= 1'b1;
      tick(30);
      chk(core_reset_o, 1'b0, "trip ignored");
      @(posedge clk_i);
      trip_cmd <= 1'b0;
      // external pin reset
      wr(MASK, 8'h00);
      @(posedge clk_i);
      pin_low_cmd <= 1'b1;
      wait_core(1'b1, 10);
      pin_low_cmd <= 1'b0;
      wait_core(1'b0, 60);
      rd_chk(SRC, 8'h01, "pin cause");
      // brownout counts as power-on; fell event masked
      @(posedge clk_i);
      supply_cmd <= 1'b0;
      wait_core(1'b1, 10);
      tick(1);
      chk(irq_o, 1'b0, "masked event");
      wr(CTRL, 8'hb0);
      rd_chk(CTRL, 8'h90, "defaults in hold");
      // supply lost again inside the delay: the count starts over
      @(posedge clk_i);
      supply_cmd <= 1'b1;
      repeat (6) @(posedge clk_i);
      supply_cmd <= 1'b0;
      tick(DLY + 8);
      chk(core_reset_o, 1'b1, "abort in delay");
      @(posedge clk_i);
      supply_cmd <= 1'b1;
      wait_core(1'b0, DLY + 10);
      rd_chk(SRC, 8'h02, "flag after brownout");
      // primary monitor off: supply loss raises only the interrupt
      bus(1'b0, IRQS, 8'h00, 4'hf);
      wr(MASK, 8'h01); // mask kept through power-on; now enable fell only
      wr(CTRL, 8'h10);
      tick(2);
      chk(primary_mon_en_o, 1'b0, "primary off");
      @(posedge clk_i);
      supply_cmd <= 1'b0;
      tick(30);
      chk(core_reset_o, 1'b0, "no brownout reset");
      chk(irq_o, 1'b1, "fell interrupt");
      rd_chk(IRQS, 8'h01, "fell status");
      tick(2);
      chk(irq_o, 1'b0, "fell cleared");
      rd_chk(CTRL, 8'h10, "supply status low");
      // a second reset mid-run restores the defaults
      @(posedge clk_i);
      rst_i <= 1'b1;
      repeat (3) @(posedge clk_i);
      rst_i <= 1'b0;
      tick(1);
      chk(core_reset_o, 1'b1, "held after reset");
      rd_chk(MASK, 8'h00, "mask after reset");
      rd_chk(CTRL, 8'h90, "defaults after reset");
      close_out();
   end

endmodule // tb_power_on_reset_supply_monitor
